// [edge_trig_src.v]
// edge_trig_src.v: selects one trigger line and detects its active edge.
// assumes lines are synchronous to clk_sys and sampleEn marks sample clocks.
`timescale 1ns/10ps
`include "trig_consts.vh"

module edge_trig_src (
  // clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  // sampling
  input  wire        sampleEn,
  input  wire [19:0] srcVec,
  input  wire [4:0]  srcSel,
  input  wire [6:0]  edgeSel,
  // result, valid in the sampleEn cycle
  output wire        edgeHit
);

  wire cur;
  reg  prev;

  assign cur = srcVec[srcSel];

  // previous level, updated once per sample clock
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 1'b0;
    end else if (sampleEn) begin
      prev <= cur;
    end
  end

  // unknown edge codes never fire rather than guessing a direction
  assign edgeHit = sampleEn & (
    (edgeSel == `EDGE_SEL_RISING)  ? (cur & ~prev) :
    (edgeSel == `EDGE_SEL_FALLING) ? (~cur & prev) :
    1'b0);

endmodule // edge_trig_src

// [pattern_matcher.v]
// pattern_matcher.v: per-channel mask compare with match or mismatch sense.
// assumes data is already interpreted and mask holds 3 bits per channel.
`timescale 1ns/10ps
`include "trig_consts.vh"

module pattern_matcher #(
  parameter NCH = 32
) (
  // clock and reset
  input  wire           clk_sys,
  input  wire           arst_n,
  // samples and settings
  input  wire           sampleEn,
  input  wire [NCH-1:0] dataIn,
  input  wire [3*NCH-1:0] mask,
  input  wire [6:0]     sense,
  // result, valid in the sampleEn cycle
  output wire           hit
);

  reg  [NCH-1:0] prevData;
  reg            prevValid;
  wire [NCH-1:0] ok;

  // previous sample; edges stay false until one sample has been seen
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prevData  <= {NCH{1'b0}};
      prevValid <= 1'b0;
    end else if (sampleEn) begin
      prevData  <= dataIn;
      prevValid <= 1'b1;
    end
  end

  // slot i is channel i: the last symbol lands on channel 0 and separator
  // spaces own no slot, so they never shift the mapping
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      wire [2:0] sym = mask[3*i +: 3];
      wire       rise = prevValid & dataIn[i] & ~prevData[i];
      wire       fall = prevValid & ~dataIn[i] & prevData[i];
      assign ok[i] = (sym == `SYM_ANY)    ? 1'b1 :
                     (sym == `SYM_ONE)    ? dataIn[i] :
                     (sym == `SYM_ZERO)   ? ~dataIn[i] :
                     (sym == `SYM_RISE)   ? rise :
                     (sym == `SYM_FALL)   ? fall :
                     (sym == `SYM_EITHER) ? (rise | fall) : 1'b0;
    end
  endgenerate

  // every channel takes part in the compare
  assign hit = sampleEn & (
    (sense == `SENSE_ON_MATCH)    ? (&ok) :
    (sense == `SENSE_ON_MISMATCH) ? ~(&ok) :
    1'b0);

endmodule // pattern_matcher

// [ref_advance_trigger.v]
// ref_advance_trigger.v: reference and advance trigger qualification for
// the acquisition engine, with holdoffs, alignment and export routing.
// assumes all settings are static while armed and lines are synchronous.
//
// How it works
// - edge mode detects rising (12) or falling (13) edge of the chosen source
// - assertion aligned to sample clock rising, falling, or programmed delay
// - position setting acts only for front-panel sources, not backplane
// - input terminal set differential (64) or single-ended (65)
// - exported terminal set differential or single-ended by its own setting
// - pattern mode compares every channel against its own mask symbol
// - symbols: any, one, zero, rising, falling, either edge
// - last mask symbol maps to channel 0, earlier ones upward
// - separator spaces never shift symbol-to-channel mapping
// - pattern trigger fires on match (36) or on mismatch (37)
// - compare uses interpreted channel values, not raw pin levels
// - reference trigger exported to nothing or one chosen line
// - reference events ignored until start holdoff elapses
// - start holdoff dropped when pretrigger samples exceed it
// - next record's reference ignored until ref-to-ref holdoff elapses
// - that holdoff dropped when posttrigger plus next pretrigger exceed it
// - advance types off, edge, software, pattern; off means none
// - advance trigger only in acquisition, never generation
// - advance pattern mode fires when its pattern condition holds
// - reference type off/edge/pattern/sw; non-off holds data until trigger
`timescale 1ns/10ps
`include "trig_consts.vh"

module ref_advance_trigger #(
  parameter NCH   = 32,
  parameter CNT_W = 32,
  parameter DLY_W = 8
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             arst_n,
  // acquisition control
  input  wire             acqMode,
  input  wire             sampleEn,
  input  wire             startTrig,
  input  wire             recordDone,
  input  wire [NCH-1:0]   dataIn,
  input  wire             invertData,
  // reference trigger settings
  input  wire [6:0]       refTrigType,
  input  wire [4:0]       refSrcSel,
  input  wire [6:0]       refEdgeSel,
  input  wire [6:0]       refPosSel,
  input  wire [DLY_W-1:0] refPosDelay,
  input  wire [6:0]       refTermCfg,
  input  wire [6:0]       exportTermCfg,
  input  wire [3*NCH-1:0] refMask,
  input  wire [6:0]       refSense,
  input  wire [4:0]       exportDest,
  input  wire             swRefTrig,
  // holdoffs and sample counts, all in sample clocks
  input  wire [CNT_W-1:0] pretrigSamples,
  input  wire [CNT_W-1:0] posttrigSamples,
  input  wire [CNT_W-1:0] nextPretrigSamples,
  input  wire [CNT_W-1:0] startHoldoff,
  input  wire [CNT_W-1:0] refHoldoff,
  // advance trigger settings
  input  wire [6:0]       advTrigType,
  input  wire             advEdgeIn,
  input  wire [3*NCH-1:0] advMask,
  input  wire [6:0]       advSense,
  input  wire             swAdvTrig,
  // trigger lines: front panel, backplane, system
  input  wire [3:0]       frontPanelTrigLineIn,
  input  wire [7:0]       backplaneTrigLineIn,
  input  wire [7:0]       systemTrigLineIn,
  output reg  [3:0]       frontPanelTrigLineOut,
  output reg  [3:0]       frontPanelTrigLineOe,
  output reg  [6:0]       backplaneTrigLineOut,
  output reg  [6:0]       backplaneTrigLineOe,
  output reg  [6:0]       systemTrigLineOut,
  output reg  [6:0]       systemTrigLineOe,
  // terminal configuration
  output reg              refTermDiff,
  output reg              exportTermDiff,
  // results
  output reg              refTrig,
  output reg              advTrig,
  output reg              dataHold,
  output reg              refArmed
);

  ////////////////////////////////////////////////////////////////////////
  // state

  reg  [CNT_W-1:0] holdCnt;
  reg  [DLY_W:0]   alignCnt;
  reg              advRunning;
  reg              swRefPend;
  reg              swAdvPend;

  reg  [CNT_W-1:0] next_holdCnt;
  reg  [DLY_W:0]   next_alignCnt;
  reg              next_refArmed;
  reg              next_refTrig;
  reg              next_advTrig;
  reg              next_swRefPend;
  reg              next_swAdvPend;
  reg  [DLY_W:0]   delaySel;
  reg              refCond;
  reg              advCond;

  wire [NCH-1:0]   interpData;
  wire [19:0]      srcVec;
  wire             edgeHit;
  wire             refPatHit;
  wire             advPatHit;
  wire             fromFront;
  wire             refQual;
  wire [CNT_W:0]   gapSamples;
  wire [17:0]      next_lineOut;
  wire [17:0]      next_lineOe;

  ////////////////////////////////////////////////////////////////////////
  // sources and compare engines

  // pattern compare sees the interpreted values
  assign interpData = dataIn ^ {NCH{invertData}};
  assign srcVec     = {systemTrigLineIn, backplaneTrigLineIn,
                       frontPanelTrigLineIn};

  edge_trig_src u_edge (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .sampleEn (sampleEn),
    .srcVec   (srcVec),
    .srcSel   (refSrcSel),
    .edgeSel  (refEdgeSel),
    .edgeHit  (edgeHit)
  );

  pattern_matcher #(.NCH(NCH)) u_refPat (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .sampleEn (sampleEn),
    .dataIn   (interpData),
    .mask     (refMask),
    .sense    (refSense),
    .hit      (refPatHit)
  );

  pattern_matcher #(.NCH(NCH)) u_advPat (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .sampleEn (sampleEn),
    .dataIn   (interpData),
    .mask     (advMask),
    .sense    (advSense),
    .hit      (advPatHit)
  );

  ////////////////////////////////////////////////////////////////////////
  // reference qualification

  // position only means something on a front-panel edge source
  assign fromFront = (refTrigType == `TRIG_TYPE_EDGE) &
                     (refSrcSel < `SRC_FP_COUNT);

  // extra cycles between detection and assertion
  always @* begin
    delaySel = {(DLY_W+1){1'b0}};
    if (fromFront) begin
      case (refPosSel)
        `POS_CLK_FALLING: delaySel = {{DLY_W{1'b0}}, 1'b1};
        `POS_CLK_DELAY:   delaySel = {1'b0, refPosDelay};
        default:          delaySel = {(DLY_W+1){1'b0}};
      endcase
    end
  end

  // trigger condition for the selected type
  always @* begin
    case (refTrigType)
      `TRIG_TYPE_EDGE:    refCond = edgeHit;
      `TRIG_TYPE_PATTERN: refCond = refPatHit;
      `TRIG_TYPE_SW:      refCond = sampleEn & swRefPend;
      default:            refCond = 1'b0;
    endcase
  end

  // an event counts only when armed and any holdoff has run out
  assign refQual = acqMode & refArmed & (holdCnt == {CNT_W{1'b0}})
                   & refCond;

  // next record's gap, one bit wider so the sum cannot wrap
  assign gapSamples = {1'b0, posttrigSamples} + {1'b0, nextPretrigSamples};

  ////////////////////////////////////////////////////////////////////////
  // reference next state

  always @* begin
    next_holdCnt   = holdCnt;
    next_alignCnt  = alignCnt;
    next_refArmed  = refArmed;
    next_refTrig   = 1'b0;
    next_swRefPend = swRefPend | swRefTrig;
    // holdoff runs in sample clocks
    if (sampleEn && holdCnt != {CNT_W{1'b0}}) begin
      next_holdCnt = holdCnt - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    // pending aligned assertion, counted in clocks
    // only a start trigger cancels it, a type change does not
    if (alignCnt != {(DLY_W+1){1'b0}}) begin
      next_alignCnt = alignCnt - {{DLY_W{1'b0}}, 1'b1};
      if (alignCnt == {{DLY_W{1'b0}}, 1'b1}) begin
        next_refTrig = 1'b1;
      end
    end
    // a qualified event fires now or after the alignment delay
    if (refQual) begin
      next_refArmed = 1'b0;
      if (refTrigType == `TRIG_TYPE_SW) begin
        next_swRefPend = swRefTrig;
      end
      if (delaySel == {(DLY_W+1){1'b0}}) begin
        next_refTrig = 1'b1;
      end else begin
        next_alignCnt = delaySel;
      end
    end
    // ref-to-ref holdoff starts as the reference asserts
    if (next_refTrig) begin
      if (gapSamples > {1'b0, refHoldoff}) begin
        next_holdCnt = {CNT_W{1'b0}};
      end else begin
        next_holdCnt = refHoldoff;
      end
    end
    // next record re-arms, keeping any holdoff still running
    if (recordDone && refTrigType != `TRIG_TYPE_OFF) begin
      next_refArmed = acqMode;
    end
    // start trigger arms and loads the start holdoff
    if (startTrig) begin
      next_refArmed = acqMode & (refTrigType != `TRIG_TYPE_OFF);
      next_alignCnt = {(DLY_W+1){1'b0}};
      if (pretrigSamples > startHoldoff) begin
        next_holdCnt = {CNT_W{1'b0}};
      end else begin
        next_holdCnt = startHoldoff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // advance trigger

  // software advance waits for its explicit command
  always @* begin
    case (advTrigType)
      `TRIG_TYPE_EDGE:    advCond = sampleEn & advEdgeIn;
      `TRIG_TYPE_PATTERN: advCond = advPatHit;
      `TRIG_TYPE_SW:      advCond = sampleEn & swAdvPend;
      default:            advCond = 1'b0;
    endcase
    next_advTrig   = acqMode & advRunning & advCond;
    next_swAdvPend = swAdvPend | swAdvTrig;
    // a command in the consuming cycle is kept for the next one
    if (next_advTrig && advTrigType == `TRIG_TYPE_SW) begin
      next_swAdvPend = swAdvTrig;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // export routing: one line at most, chosen by exportDest

  genvar k;
  generate
    for (k = 0; k < 18; k = k + 1) begin : g_line
      // integer index, cut to the port width on purpose
      localparam integer DEST = k + 1;
      assign next_lineOe[k]  = (exportDest == DEST[4:0]);
      assign next_lineOut[k] = next_refTrig & next_lineOe[k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers

  // every output comes from a flop; hold covers armed and pending delay
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt               <= {CNT_W{1'b0}};
      alignCnt              <= {(DLY_W+1){1'b0}};
      refArmed              <= 1'b0;
      refTrig               <= 1'b0;
      advTrig               <= 1'b0;
      advRunning            <= 1'b0;
      swRefPend             <= 1'b0;
      swAdvPend             <= 1'b0;
      dataHold              <= 1'b0;
      refTermDiff           <= `RST_TERM_DIFF;
      exportTermDiff        <= `RST_TERM_DIFF;
      frontPanelTrigLineOut <= 4'h0;
      frontPanelTrigLineOe  <= 4'h0;
      backplaneTrigLineOut  <= 7'h00;
      backplaneTrigLineOe   <= 7'h00;
      systemTrigLineOut     <= 7'h00;
      systemTrigLineOe      <= 7'h00;
    end else begin
      holdCnt   <= next_holdCnt;
      alignCnt  <= next_alignCnt;
      refArmed  <= next_refArmed;
      refTrig   <= next_refTrig;
      advTrig   <= next_advTrig;
      swRefPend <= next_swRefPend;
      swAdvPend <= next_swAdvPend;
      // advance runs from start while acquiring
      if (startTrig) begin
        advRunning <= acqMode;
      end else if (!acqMode) begin
        advRunning <= 1'b0;
      end
      dataHold <= next_refArmed |
                  (next_alignCnt != {(DLY_W+1){1'b0}});
      // unknown codes fall back to single-ended, the safer drive
      refTermDiff    <= (refTermCfg == `TERM_CFG_DIFFERENTIAL);
      exportTermDiff <= (exportTermCfg == `TERM_CFG_DIFFERENTIAL);
      frontPanelTrigLineOut <= next_lineOut[3:0];
      frontPanelTrigLineOe  <= next_lineOe[3:0];
      backplaneTrigLineOut  <= next_lineOut[10:4];
      backplaneTrigLineOe   <= next_lineOe[10:4];
      systemTrigLineOut     <= next_lineOut[17:11];
      systemTrigLineOe      <= next_lineOe[17:11];
    end
  end

endmodule // ref_advance_trigger

// [ref_trig_chk_sva.sv]
// ref_trig_chk_sva.sv: port-level checks on the reference/advance trigger block.
// assumes one clock domain and settings held static while armed.
`timescale 1ns/10ps
`include "trig_consts.vh"

module ref_trig_chk (
  // clock and reset
  input wire       clk_sys,
  input wire       arst_n,
  // watched settings
  input wire       acqMode,
  input wire       swAdvTrig,
  input wire [6:0] advTrigType,
  input wire [6:0] refTrigType,
  input wire [6:0] refTermCfg,
  input wire [6:0] exportTermCfg,
  // watched lines
  input wire [3:0] frontPanelTrigLineOut,
  input wire [3:0] frontPanelTrigLineOe,
  input wire [6:0] backplaneTrigLineOut,
  input wire [6:0] backplaneTrigLineOe,
  input wire [6:0] systemTrigLineOut,
  input wire [6:0] systemTrigLineOe,
  // watched results
  input wire       refTermDiff,
  input wire       exportTermDiff,
  input wire       refTrig,
  input wire       advTrig,
  input wire       dataHold,
  input wire       refArmed
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  wire [17:0] oeAll  = {systemTrigLineOe, backplaneTrigLineOe, frontPanelTrigLineOe};
  wire [17:0] outAll = {systemTrigLineOut, backplaneTrigLineOut, frontPanelTrigLineOut};

  // sticky: has any software advance command been seen yet
  reg swSeen;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) swSeen <= 1'b0;
    else if (swAdvTrig) swSeen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_adv_off; advTrigType == `TRIG_TYPE_OFF |=> !advTrig; endproperty
  a_adv_off: assert property (p_adv_off) else $error("advance fired while off");
  property p_no_gen; !acqMode |=> !advTrig; endproperty
  a_no_gen: assert property (p_no_gen) else $error("advance fired in generation");
  property p_sw_adv; advTrigType == `TRIG_TYPE_SW && !swSeen && !swAdvTrig |=> !advTrig;
  endproperty
  a_sw_adv: assert property (p_sw_adv) else $error("advance without command");
  property p_ref_off; refTrigType == `TRIG_TYPE_OFF |=> !refTrig; endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference fired while off");
  property p_one_shot; refTrig |-> !refArmed ##1 !refTrig; endproperty
  a_one_shot: assert property (p_one_shot) else $error("reference not one shot");
  property p_armed_hold; refArmed |-> dataHold; endproperty
  a_armed_hold: assert property (p_armed_hold) else $error("armed but data free");
  property p_no_arm; !dataHold |=> !refTrig; endproperty
  a_no_arm: assert property (p_no_arm) else $error("reference while idle");
  property p_term_ref; refTermCfg == `TERM_CFG_DIFFERENTIAL || refTermCfg == `TERM_CFG_SINGLE
    |=> refTermDiff == $past(refTermCfg == `TERM_CFG_DIFFERENTIAL); endproperty
  a_term_ref: assert property (p_term_ref) else $error("input terminal wrong");
  property p_term_exp; exportTermCfg == `TERM_CFG_DIFFERENTIAL
    || exportTermCfg == `TERM_CFG_SINGLE
    |=> exportTermDiff == $past(exportTermCfg == `TERM_CFG_DIFFERENTIAL); endproperty
  a_term_exp: assert property (p_term_exp) else $error("export terminal wrong");
  property p_export; outAll == (oeAll & {18{refTrig}}) && $onehot0(oeAll); endproperty
  a_export: assert property (p_export) else $error("export lines wrong");

  // main scenarios reached
  c_ref: cover property (refTrig);
  c_adv: cover property (advTrig);
  c_bp: cover property (refTrig && (backplaneTrigLineOut != 7'h00));
endmodule // ref_trig_chk

bind ref_advance_trigger ref_trig_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .acqMode(acqMode), .swAdvTrig(swAdvTrig), .advTrigType(advTrigType),
  .refTrigType(refTrigType), .refTermCfg(refTermCfg), .exportTermCfg(exportTermCfg),
  .frontPanelTrigLineOut(frontPanelTrigLineOut), .frontPanelTrigLineOe(frontPanelTrigLineOe),
  .backplaneTrigLineOut(backplaneTrigLineOut), .backplaneTrigLineOe(backplaneTrigLineOe),
  .systemTrigLineOut(systemTrigLineOut), .systemTrigLineOe(systemTrigLineOe),
  .refTermDiff(refTermDiff), .exportTermDiff(exportTermDiff), .refTrig(refTrig),
  .advTrig(advTrig), .dataHold(dataHold), .refArmed(refArmed));

// [tb.sv]
// tb.sv: self-checking bench for the reference and advance trigger block.
// assumes a 50 MHz clock; inputs move 1 ns after each rising edge.
`timescale 1ns/10ps
`include "trig_consts.vh"

module tb;
  localparam [6:0] RI = `EDGE_SEL_RISING, FA = `EDGE_SEL_FALLING;
  localparam [6:0] P18 = `POS_CLK_RISING, P19 = `POS_CLK_FALLING, P20 = `POS_CLK_DELAY;
  localparam [6:0] MA = `SENSE_ON_MATCH, MI = `SENSE_ON_MISMATCH;
  reg        clk_sys = 0, arst_n = 0, acqMode = 1, sampleEn = 0, startTrig = 0;
  reg        recordDone = 0, invertData = 0, swRefTrig = 0, swAdvTrig = 0, advEdgeIn = 0;
  reg [31:0] dataIn = 0, pre = 0, post = 0, nextPre = 0, stHold = 0, rrHold = 0;
  reg [6:0]  rType = `TRIG_TYPE_OFF, rEdge = RI, rPos = P18, rSense = MA, aSense = MA;
  reg [6:0]  rTerm = `TERM_CFG_DIFFERENTIAL, xTerm = `TERM_CFG_DIFFERENTIAL;
  reg [6:0]  aType = `TRIG_TYPE_OFF;
  reg [4:0]  rSrc = 0, xDest = 0;
  reg [7:0]  rDly = 0;
  reg [95:0] rMask = 0, aMask = 0;
  wire [3:0] fpIn, fpOut, fpOe;
  wire [7:0] bpIn, sysIn;
  wire [6:0] bpOut, bpOe, sysOut, sysOe;
  wire       refTermDiff, exportTermDiff, refTrig, advTrig, dataHold, refArmed;
  integer    mismatches = 0, n_checks = 0;

  trig_line_src src_m (.fpLine(fpIn), .bpLine(bpIn), .sysLine(sysIn));
  ref_advance_trigger uut (.clk_sys(clk_sys), .arst_n(arst_n), .acqMode(acqMode),
    .sampleEn(sampleEn), .startTrig(startTrig), .recordDone(recordDone), .dataIn(dataIn),
    .invertData(invertData), .refTrigType(rType), .refSrcSel(rSrc), .refEdgeSel(rEdge),
    .refPosSel(rPos), .refPosDelay(rDly), .refTermCfg(rTerm), .exportTermCfg(xTerm),
    .refMask(rMask), .refSense(rSense), .exportDest(xDest), .swRefTrig(swRefTrig),
    .pretrigSamples(pre), .posttrigSamples(post), .nextPretrigSamples(nextPre),
    .startHoldoff(stHold), .refHoldoff(rrHold), .advTrigType(aType), .advEdgeIn(advEdgeIn),
    .advMask(aMask), .advSense(aSense), .swAdvTrig(swAdvTrig), .frontPanelTrigLineIn(fpIn),
    .backplaneTrigLineIn(bpIn), .systemTrigLineIn(sysIn), .frontPanelTrigLineOut(fpOut),
    .frontPanelTrigLineOe(fpOe), .backplaneTrigLineOut(bpOut), .backplaneTrigLineOe(bpOe),
    .systemTrigLineOut(sysOut), .systemTrigLineOe(sysOe), .refTermDiff(refTermDiff),
    .exportTermDiff(exportTermDiff), .refTrig(refTrig), .advTrig(advTrig),
    .dataHold(dataHold), .refArmed(refArmed));

  // free-running 50 MHz clock
  initial forever #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task chk(input [31:0] seen, exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task tick; @(posedge clk_sys); #1; endtask
  // leading tick keeps sampleEn from being set twice in one step
  task smp; tick; sampleEn = 1; tick; sampleEn = 0; endtask
  task arm(input bit d);
    if (d) recordDone = 1;
    else startTrig = 1;
    tick;
    startTrig = 0;
    recordDone = 0;
  endtask
  // clock edges up to refTrig, the qualifying sample edge counted as 1; 99 if none
  task waitRef(output integer n);
    n = 1;
    while (refTrig !== 1'b1 && n < 40) begin
      tick;
      n = n + 1;
    end
    if (n == 40) n = 99;
  endtask
  function [95:0] sym(input integer ch, input [2:0] s);
    sym = {93'h0, s} << (3 * ch);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task edgeTrial(input integer src, input [6:0] es, ps, input [7:0] d,
                 input bit rise, done, input integer exp);
    integer n;
    rType = `TRIG_TYPE_EDGE;
    rSrc = src[4:0];
    rEdge = es;
    rPos = ps;
    rDly = d;
    src_m.setLine(src, !rise);
    arm(done);
    chk({refArmed, dataHold}, 3);
    smp;
    src_m.setLine(src, rise);
    smp;
    waitRef(n);
    chk(n, exp);
    src_m.setLine(src, 0);
  endtask
  task patTrial(input [95:0] m, input [6:0] sn, input bit inv, input [31:0] d0, d1,
                input integer exp);
    integer n;
    rType = `TRIG_TYPE_PATTERN;
    rMask = m;
    rSense = sn;
    invertData = inv;
    dataIn = d0;
    smp;
    arm(0);
    dataIn = d1;
    smp;
    waitRef(n);
    chk(n, exp);
  endtask
  task termScn;
    integer i;
    for (i = 0; i < 2; i = i + 1) begin
      rTerm = i ? `TERM_CFG_SINGLE : `TERM_CFG_DIFFERENTIAL;
      xTerm = i ? `TERM_CFG_DIFFERENTIAL : `TERM_CFG_SINGLE;
      tick;
      chk(refTermDiff, i == 0);
      chk(exportTermDiff, i == 1);
    end
  endtask
  task expScn;
    integer d;
    for (d = 0; d < 19; d = d + 1) begin
      xDest = d[4:0];
      tick;
      chk({sysOe, bpOe, fpOe}, d == 0 ? 0 : 32'h1 << (d - 1));
    end
    xDest = 5'h06;
    edgeTrial(4, RI, P18, 0, 1, 0, 1);
    chk({sysOut, bpOut, fpOut}, 32'h20);
  endtask
  task edgeScn;
    edgeTrial(0, RI, P18, 0, 1, 0, 1);
    edgeTrial(2, FA, P18, 0, 0, 0, 1);
    edgeTrial(1, RI, P18, 0, 0, 0, 99);
    edgeTrial(3, FA, P19, 0, 0, 0, 2);
    edgeTrial(0, RI, P20, 3, 1, 0, 4);
    edgeTrial(0, RI, P20, 0, 1, 0, 1);
    edgeTrial(5, RI, P20, 3, 1, 0, 1);
    edgeTrial(14, RI, P19, 0, 1, 0, 1);
  endtask
  // pretrigger and posttrigger counts stay within the record length
  task holdScn;
    stHold = 3;
    pre = 1;
    edgeTrial(0, RI, P18, 0, 1, 0, 99);
    pre = 3;
    edgeTrial(0, RI, P18, 0, 1, 0, 99);
    pre = 4;
    edgeTrial(0, RI, P18, 0, 1, 0, 1);
    stHold = 0;
    rrHold = 3;
    post = 2;
    nextPre = 2;
    edgeTrial(0, RI, P18, 0, 1, 1, 1);
    edgeTrial(0, RI, P18, 0, 1, 1, 1);
    nextPre = 1;
    edgeTrial(0, RI, P18, 0, 1, 1, 1);
    edgeTrial(0, RI, P18, 0, 1, 1, 99);
    rrHold = 0;
    repeat (4) smp;
  endtask
  task patScn;
    reg [95:0] m;
    m = sym(0, `SYM_ONE) | sym(1, `SYM_ZERO) | sym(31, `SYM_ONE);
    patTrial(m, MA, 0, 0, 32'h80000001, 1);
    patTrial(m, MI, 0, 0, 32'h80000001, 99);
    patTrial(m, MI, 0, 0, 32'h00000001, 1);
    patTrial(m, MA, 1, 0, 32'h7ffffffe, 1);
    patTrial(sym(5, `SYM_RISE), MA, 0, 0, 32'h20, 1);
    patTrial(sym(5, `SYM_FALL), MA, 0, 32'h20, 0, 1);
    patTrial(sym(5, `SYM_EITHER), MA, 0, 32'h20, 0, 1);
    patTrial(sym(5, `SYM_EITHER), MA, 0, 0, 32'h20, 1);
    patTrial(sym(5, `SYM_FALL), MA, 0, 0, 32'h20, 99);
    patTrial(sym(4, `SYM_ZERO), MA, 0, 32'h10, 32'h10, 99);
  endtask
  task typeScn;
    integer n;
    rType = `TRIG_TYPE_SW;
    arm(0);
    smp;
    chk(refTrig, 0);
    swRefTrig = 1;
    tick;
    swRefTrig = 0;
    smp;
    waitRef(n);
    chk(n, 1);
  endtask
  task advSmp(input bit exp);
    smp;
    chk(advTrig, exp);
  endtask
  // software command comes only from the controlling party
  task advScn;
    rType = `TRIG_TYPE_OFF;
    aMask = sym(0, `SYM_ONE);
    dataIn = 1;
    advEdgeIn = 1;
    arm(0);
    advSmp(0);
    aType = `TRIG_TYPE_EDGE;
    advSmp(1);
    advEdgeIn = 0;
    advSmp(0);
    aType = `TRIG_TYPE_PATTERN;
    advSmp(1);
    dataIn = 0;
    advSmp(0);
    aType = `TRIG_TYPE_SW;
    advSmp(0);
    swAdvTrig = 1;
    tick;
    swAdvTrig = 0;
    advSmp(1);
    advSmp(0);
    aType = `TRIG_TYPE_EDGE;
    advEdgeIn = 1;
    acqMode = 0;
    advSmp(0);
    acqMode = 1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    arst_n = 1;
    termScn;
    expScn;
    edgeScn;
    holdScn;
    patScn;
    typeScn;
    advScn;
    wrap_up;
  end

  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #400000;
    mismatches = mismatches + 1;
    wrap_up;
  end
endmodule // tb

// [trig_consts.vh]
// trig_consts.vh: setting codes, mask symbols and reset values for the
// reference/advance trigger qualifier.
// assumes settings arrive as plain 7-bit code ports from software.
`ifndef TRIG_CONSTS_VH
`define TRIG_CONSTS_VH

// active edge select
`define EDGE_SEL_RISING       7'h0c
`define EDGE_SEL_FALLING      7'h0d
// position relative to the sample clock
`define POS_CLK_RISING        7'h12
`define POS_CLK_FALLING       7'h13
`define POS_CLK_DELAY         7'h14
// trigger types
`define TRIG_TYPE_OFF         7'h1c
`define TRIG_TYPE_EDGE        7'h1d
`define TRIG_TYPE_PATTERN     7'h1f
`define TRIG_TYPE_SW          7'h20
// pattern match sense
`define SENSE_ON_MATCH        7'h24
`define SENSE_ON_MISMATCH     7'h25
// terminal configuration
`define TERM_CFG_DIFFERENTIAL 7'h40
`define TERM_CFG_SINGLE       7'h41
// per-channel mask symbols
`define SYM_ANY               3'h0
`define SYM_ONE               3'h1
`define SYM_ZERO              3'h2
`define SYM_RISE              3'h3
`define SYM_FALL              3'h4
`define SYM_EITHER            3'h5
// source index: below this it is a front-panel line
`define SRC_FP_COUNT          5'h04
// export destination: 0 none, 1..4 front, 5..11 backplane, 12..18 system
`define DEST_NONE             5'h00
// reset values
`define RST_TERM_DIFF         1'b0
`define RST_DELAY_CNT         8'h00

`endif

// [trig_line_src.sv]
// trig_line_src.sv: external trigger sources on front panel, backplane, system lines.
// assumes the bench moves levels just after a clock edge.
`timescale 1ns/10ps

module trig_line_src (
  // line levels toward the block
  output wire [3:0] fpLine,
  output wire [7:0] bpLine,
  output wire [7:0] sysLine
);
  // one level per source index, front panel first
  reg [19:0] lvl = 20'h00000;

  // lines are actively driven, never left floating
  task setLine(input integer idx, input bit v);
    lvl[idx] = v;
  endtask

  assign fpLine  = lvl[3:0];
  assign bpLine  = lvl[11:4];
  assign sysLine = lvl[19:12];
endmodule // trig_line_src
